// *** verilog/tirf_consts.svh ***
// Offsets, field positions, reset values and timing counts for the timer flag block
`ifndef TIRF_CONSTS_SVH
`define TIRF_CONSTS_SVH
`define TIRF_ADDR_IRQ_ENABLE_ONE 8'h22
`define TIRF_ADDR_EVENT_FLAGS_ONE 8'h23
`define TIRF_ADDR_IRQ_ENABLE_TWO 8'h24
`define TIRF_ADDR_EVENT_FLAGS_TWO 8'h25
`define TIRF_RESET_BYTE 8'h00
`define TIRF_BIT_SHARED45 3
`define TIRF_BIT_OVERFLOW 7
`define TIRF_BIT_PERIODIC 6
`define TIRF_BIT_ACC_OVF 5
`define TIRF_BIT_ACC_EDGE 4
`define TIRF_PRESCALE_WINDOW_CYCLES 7'h40
`define TIRF_PERIODIC_BASE_BITS 13
`define TIRF_COUNTER_MAX 16'hFFFF
`endif

// *** verilog/tirf_pkg.sv ***
// Types shared by the timer flag block
package tirf_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tirf_bus_type;

    typedef struct packed {
        logic [3:0] compare;
        logic compare_five;
        logic capture_four;
        logic [2:0] capture;
        logic accum_overflow;
        logic accum_edge;
    } tirf_events_type;
endpackage : tirf_pkg

// *** verilog/tirf_counter.sv ***
// Prescaled 16-bit free-running counter with wrap pulse
`timescale 1ns/1ns
`default_nettype none
`include "tirf_consts.svh"
module tirf_counter
    import tirf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] prescale_select,
    output logic [15:0] count,
    output logic overflow
);
    logic [3:0] pre_count;
    logic tick;

    function automatic logic [3:0] tirf_prescale_mask(input logic [1:0] sel);
        case (sel)
            2'h0: tirf_prescale_mask = 4'h0;
            2'h1: tirf_prescale_mask = 4'h3;
            2'h2: tirf_prescale_mask = 4'h7;
            default: tirf_prescale_mask = 4'hF;
        endcase
    endfunction : tirf_prescale_mask

    // Divide by 1, 4, 8 or 16
    assign tick = (pre_count & tirf_prescale_mask(prescale_select))
        == tirf_prescale_mask(prescale_select);

    always_ff @(posedge clk)
    begin
        if (rst)
            pre_count <= 4'h0;
        else
            pre_count <= pre_count + 4'h1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            count <= 16'h0000;
        else if (tick)
            count <= count + 16'h0001;
    end

    // Wrap from all ones to zero
    always_ff @(posedge clk)
    begin
        if (rst)
            overflow <= 1'b0;
        else
            overflow <= tick && (count == `TIRF_COUNTER_MAX);
    end
endmodule : tirf_counter
`default_nettype wire

// *** verilog/tirf_periodic.sv ***
// Free-running periodic timeout generator
`timescale 1ns/1ns
`default_nettype none
`include "tirf_consts.svh"
module tirf_periodic
    import tirf_pkg::*;
#(
    parameter int BASE_BITS = `TIRF_PERIODIC_BASE_BITS
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] rate_select,
    output logic timeout
);
    logic [BASE_BITS+2:0] divider;
    logic [BASE_BITS+2:0] period_mask;

    // Base of 2^BASE_BITS bus clocks, rate adds up to three more doublings
    assign period_mask = {{3{1'b0}}, {BASE_BITS{1'b1}}}
        | ({{BASE_BITS{1'b0}}, 3'h7 >> (2'h3 - rate_select)} << BASE_BITS);

    // Only reset stops it, so clearing the flag never shifts the phase
    always_ff @(posedge clk)
    begin
        if (rst)
            divider <= '0;
        else
            divider <= divider + {{(BASE_BITS+2){1'b0}}, 1'b1};
    end

    // First timeout only after one whole period from reset
    always_ff @(posedge clk)
    begin
        if (rst)
            timeout <= 1'b0;
        else
            timeout <= (divider & period_mask) == period_mask;
    end
endmodule : tirf_periodic
`default_nettype wire

// *** verilog/tirf_top.sv ***
// Timer interrupt enables, event flags, prescaler select and periodic interrupt
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "tirf_consts.svh"
module tirf_top
    import tirf_pkg::*;
#(
    parameter int PERIODIC_BASE_BITS = `TIRF_PERIODIC_BASE_BITS
)
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic NORMAL_MODE,
    input wire logic CH45_FUNCTION_SELECT,
    input wire logic [1:0] PERIODIC_RATE_SELECT,
    input wire logic [3:0] COMPARE_EVENT,
    input wire logic COMPARE_FIVE_EVENT,
    input wire logic CAPTURE_FOUR_EVENT,
    input wire logic [2:0] CAPTURE_EVENT,
    input wire logic ACCUM_OVERFLOW_EVENT,
    input wire logic ACCUM_EDGE_EVENT,
    output logic [15:0] FREE_RUNNING_COUNTER,
    output logic [7:0] IRQ_ONE,
    output logic [3:0] IRQ_TWO
);
    tirf_bus_type bus;
    tirf_events_type ev;
    logic [7:0] timer_irq_enable_one;
    logic [7:0] timer_event_flags_one;
    logic [3:0] irq_enable_two_hi;
    logic [1:0] prescale_select;
    logic [3:0] event_flags_two_hi;
    logic [6:0] window_count;
    logic prescale_written;
    logic prescale_open;
    logic counter_overflow;
    logic periodic_timeout;
    logic [7:0] set_one;
    logic [3:0] set_two;
    logic [7:0] clear_one;
    logic [3:0] clear_two;
    logic [7:0] next_rdata;

    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
    assign ev = '{compare: COMPARE_EVENT, compare_five: COMPARE_FIVE_EVENT,
        capture_four: CAPTURE_FOUR_EVENT, capture: CAPTURE_EVENT,
        accum_overflow: ACCUM_OVERFLOW_EVENT, accum_edge: ACCUM_EDGE_EVENT};

    function automatic logic tirf_hit(input tirf_bus_type b, input logic [7:0] offset);
        tirf_hit = b.wr && (b.addr == offset);
    endfunction : tirf_hit

    tirf_counter u_counter (
        .clk(MCLK),
        .rst(RST),
        .prescale_select(prescale_select),
        .count(FREE_RUNNING_COUNTER),
        .overflow(counter_overflow)
    );

    tirf_periodic #(
        .BASE_BITS(PERIODIC_BASE_BITS)
    ) u_periodic (
        .clk(MCLK),
        .rst(RST),
        .rate_select(PERIODIC_RATE_SELECT),
        .timeout(periodic_timeout)
    );

    // Flag sources; order follows the enable layout
    assign set_one = {ev.compare,
        CH45_FUNCTION_SELECT ? ev.capture_four : ev.compare_five,
        ev.capture};
    assign set_two = {counter_overflow, periodic_timeout,
        ev.accum_overflow, ev.accum_edge};
    assign clear_one = tirf_hit(bus, `TIRF_ADDR_EVENT_FLAGS_ONE) ? bus.wdata : 8'h00;
    assign clear_two = tirf_hit(bus, `TIRF_ADDR_EVENT_FLAGS_TWO) ? bus.wdata[7:4] : 4'h0;

    // A set in the same cycle as a clear survives
    always_ff @(posedge MCLK)
    begin
        if (RST)
            timer_event_flags_one <= `TIRF_RESET_BYTE;
        else
            timer_event_flags_one <= (timer_event_flags_one & ~clear_one) | set_one;
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
            event_flags_two_hi <= 4'h0;
        else
            event_flags_two_hi <= (event_flags_two_hi & ~clear_two) | set_two;
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
            timer_irq_enable_one <= `TIRF_RESET_BYTE;
        else if (tirf_hit(bus, `TIRF_ADDR_IRQ_ENABLE_ONE))
            timer_irq_enable_one <= bus.wdata;
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
            irq_enable_two_hi <= 4'h0;
        else if (tirf_hit(bus, `TIRF_ADDR_IRQ_ENABLE_TWO))
            irq_enable_two_hi <= bus.wdata[7:4];
    end

    // Counts bus cycles since reset, saturating once the window has closed
    always_ff @(posedge MCLK)
    begin
        if (RST)
            window_count <= 7'h00;
        else if (window_count != `TIRF_PRESCALE_WINDOW_CYCLES)
            window_count <= window_count + 7'h01;
    end

    // Locking the divider early keeps software from disturbing timed channels later
    assign prescale_open = !NORMAL_MODE
        || (!prescale_written && window_count < `TIRF_PRESCALE_WINDOW_CYCLES);

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            prescale_select <= 2'h0;
            prescale_written <= 1'b0;
        end
        else if (tirf_hit(bus, `TIRF_ADDR_IRQ_ENABLE_TWO) && prescale_open)
        begin
            prescale_select <= bus.wdata[1:0];
            prescale_written <= 1'b1;
        end
    end

    // Requests follow flag and enable with one cycle of register delay
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            IRQ_ONE <= 8'h00;
            IRQ_TWO <= 4'h0;
        end
        else
        begin
            IRQ_ONE <= timer_event_flags_one & timer_irq_enable_one;
            IRQ_TWO <= event_flags_two_hi & irq_enable_two_hi;
        end
    end

    always_comb
    begin
        next_rdata = 8'h00;
        if (bus.rd)
        begin
            if (bus.addr == `TIRF_ADDR_IRQ_ENABLE_ONE)
                next_rdata = timer_irq_enable_one;
            else if (bus.addr == `TIRF_ADDR_EVENT_FLAGS_ONE)
                next_rdata = timer_event_flags_one;
            else if (bus.addr == `TIRF_ADDR_IRQ_ENABLE_TWO)
                next_rdata = {irq_enable_two_hi, 2'h0, prescale_select};
            else if (bus.addr == `TIRF_ADDR_EVENT_FLAGS_TWO)
                next_rdata = {event_flags_two_hi, 4'h0};
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
            RDATA <= 8'h00;
        else
            RDATA <= next_rdata;
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    chk_compare_sets_flag: assert property (ev.compare[3] |=> timer_event_flags_one[7])
        else $error("compare event did not set its flag");
    chk_clear_by_one: assert property (
        tirf_hit(bus, `TIRF_ADDR_EVENT_FLAGS_ONE) && bus.wdata[0] && !ev.capture[0]
        |=> !timer_event_flags_one[0])
        else $error("write of one did not clear flag");
    chk_zero_keeps_flag: assert property (
        tirf_hit(bus, `TIRF_ADDR_EVENT_FLAGS_TWO) && !bus.wdata[7] && event_flags_two_hi[3]
        |=> event_flags_two_hi[3])
        else $error("write of zero changed a flag");
    chk_compare_irq_path: assert property (
        timer_event_flags_one[7] && timer_irq_enable_one[7] |=> IRQ_ONE[7])
        else $error("compare interrupt not requested");
    chk_capture_irq_path: assert property (
        timer_event_flags_one[2] && timer_irq_enable_one[2] |=> IRQ_ONE[2])
        else $error("capture interrupt not requested");
    chk_shared_select: assert property (
        CH45_FUNCTION_SELECT && ev.capture_four |=> timer_event_flags_one[3])
        else $error("capture four did not set shared flag");
    chk_overflow_masked: assert property (
        !irq_enable_two_hi[3] |=> !IRQ_TWO[3])
        else $error("overflow interrupt leaked while disabled");
    chk_prescale_locked: assert property (
        NORMAL_MODE && prescale_written && tirf_hit(bus, `TIRF_ADDR_IRQ_ENABLE_TWO)
        |=> $stable(prescale_select))
        else $error("prescale select rewritten after lock");
    chk_window_closed: assert property (
        NORMAL_MODE && window_count == `TIRF_PRESCALE_WINDOW_CYCLES
        && tirf_hit(bus, `TIRF_ADDR_IRQ_ENABLE_TWO) |=> $stable(prescale_select))
        else $error("prescale select accepted after window closed");
    chk_low_bits_zero: assert property (
        bus.rd && bus.addr == `TIRF_ADDR_EVENT_FLAGS_TWO |=> RDATA[3:0] == 4'h0)
        else $error("unimplemented flag bits read nonzero");
    // Request lags the enable by one register stage, so compare with the old enable
    chk_periodic_flag: assert property (
        periodic_timeout |=> event_flags_two_hi[2]
        ##1 IRQ_TWO[2] == $past(irq_enable_two_hi[2]))
        else $error("periodic timeout did not raise flag");
    chk_wrap_sets_flag: assert property (counter_overflow |=> event_flags_two_hi[3])
        else $error("counter wrap did not set overflow flag");

    cov_periodic_irq: cover property (periodic_timeout ##2 IRQ_TWO[2]);
    cov_overflow: cover property (counter_overflow ##1 event_flags_two_hi[3]);
    cov_prescale_write: cover property (tirf_hit(bus, `TIRF_ADDR_IRQ_ENABLE_TWO) && prescale_open);
    cov_set_and_clear: cover property (ev.compare[0] && clear_one[4]);
endmodule : tirf_top
`default_nettype wire

// *** tb/tirf_partner.sv ***
// Model of the capture, compare and accumulator logic that raises timer events
`timescale 1ns/1ns
`default_nettype none
module tirf_partner
    import tirf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire tirf_events_type req,
    output tirf_events_type evt
);
    // Events repeat the request one cycle later, so a held request gives a held event, not a pulse
    always_ff @(posedge clk)
    begin
        evt <= rst ? '0 : req;
    end
endmodule : tirf_partner
`default_nettype wire

// *** tb/tirf_top_tb.sv ***
// Self-checking bench for the timer flag block
`timescale 1ns/1ns
`default_nettype none
`include "tirf_consts.svh"
module tirf_top_tb;
    import tirf_pkg::*;
    logic MCLK = 0, RST = 1, WR = 0, RD = 0, NORMAL_MODE = 1, CH45_FUNCTION_SELECT = 1;
    logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, IRQ_ONE, m, c;
    logic [1:0] PERIODIC_RATE_SELECT = 2'h0;
    logic [3:0] IRQ_TWO;
    logic [15:0] FREE_RUNNING_COUNTER, t0;
    tirf_events_type req = '0, evt;
    logic [15:0] exp_q[$];
    logic rd_seen = 0;
    logic [15:0] note;
    int num_errors = 0, checks_done = 0, cycles = 0, n;
    tirf_top #(.PERIODIC_BASE_BITS(3)) i_tirf_top (.MCLK(MCLK), .RST(RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .NORMAL_MODE(NORMAL_MODE),
        .CH45_FUNCTION_SELECT(CH45_FUNCTION_SELECT), .PERIODIC_RATE_SELECT(PERIODIC_RATE_SELECT),
        .COMPARE_EVENT(evt.compare), .COMPARE_FIVE_EVENT(evt.compare_five),
        .CAPTURE_FOUR_EVENT(evt.capture_four), .CAPTURE_EVENT(evt.capture),
        .ACCUM_OVERFLOW_EVENT(evt.accum_overflow), .ACCUM_EDGE_EVENT(evt.accum_edge),
        .FREE_RUNNING_COUNTER(FREE_RUNNING_COUNTER), .IRQ_ONE(IRQ_ONE), .IRQ_TWO(IRQ_TWO));
    tirf_partner i_tirf_partner (.clk(MCLK), .rst(RST), .req(req), .evt(evt));
    always #5 MCLK = ~MCLK;
    task check(input logic [15:0] seen, input logic [15:0] expv);
        checks_done++;
        if (seen !== expv)
        begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : check
    task tally_and_finish;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1;
        @(posedge MCLK);
        WR <= 0;
    endtask : wr
    // Note holds the compared-bit mask above the expected byte
    task rd(input logic [7:0] a, input logic [7:0] expv, input logic [7:0] mask);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1;
        exp_q.push_back({mask, expv & mask});
        @(posedge MCLK);
        RD <= 0;
    endtask : rd
    task fire(input tirf_events_type ev);
        @(posedge MCLK);
        req <= ev;
        @(posedge MCLK);
        req <= '0;
        repeat (2) @(posedge MCLK);
    endtask : fire
    task wait_periodic(output int cnt);
        cnt = 0;
        do
        begin
            @(posedge MCLK);
            #1;
            cnt++;
        end
        while (IRQ_TWO[2] !== 1'b1 && cnt < 200);
    endtask : wait_periodic
    task reset_dut;
        @(posedge MCLK);
        RST <= 1;
        repeat (2) @(posedge MCLK);
        RST <= 0;
    endtask : reset_dut
    always @(posedge MCLK)
    begin
        if (rd_seen)
        begin
            if (exp_q.size() == 0)
                check(16'h0001, 16'h0000);
            else
            begin
                note = exp_q.pop_front();
                check({8'h00, RDATA & note[15:8]}, {8'h00, note[7:0]});
            end
        end
        rd_seen <= RD;
    end
    always @(posedge MCLK)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial
    begin
        void'($urandom(32'habd3));
        m = 8'($urandom());
        c = 8'($urandom());
        reset_dut();
        rd(`TIRF_ADDR_IRQ_ENABLE_ONE, 8'h00, 8'hFF);
        rd(`TIRF_ADDR_EVENT_FLAGS_ONE, 8'h00, 8'hFF);
        rd(`TIRF_ADDR_IRQ_ENABLE_TWO, 8'h00, 8'hFF);
        rd(`TIRF_ADDR_EVENT_FLAGS_TWO, 8'h00, 8'hBF);
        rd(8'h30, 8'h00, 8'hFF);
        wr(`TIRF_ADDR_IRQ_ENABLE_TWO, 8'h01);
        wr(`TIRF_ADDR_IRQ_ENABLE_TWO, 8'hF3);
        rd(`TIRF_ADDR_IRQ_ENABLE_TWO, 8'hF1, 8'hFF);
        @(posedge MCLK);
        #1;
        t0 = FREE_RUNNING_COUNTER;
        repeat (40) @(posedge MCLK);
        #1;
        check(FREE_RUNNING_COUNTER - t0, 16'd10);
        wr(`TIRF_ADDR_IRQ_ENABLE_TWO, 8'h01);
        wr(`TIRF_ADDR_IRQ_ENABLE_ONE, m);
        fire(tirf_events_type'({4'hF, 1'b0, 1'b1, 3'h7, 2'b00}));
        rd(`TIRF_ADDR_EVENT_FLAGS_ONE, 8'hFF, 8'hFF);
        check({8'h00, IRQ_ONE}, {8'h00, m});
        wr(`TIRF_ADDR_EVENT_FLAGS_ONE, c);
        rd(`TIRF_ADDR_EVENT_FLAGS_ONE, ~c, 8'hFF);
        wr(`TIRF_ADDR_EVENT_FLAGS_ONE, 8'hFF);
        CH45_FUNCTION_SELECT <= 0;
        fire(tirf_events_type'({4'h0, 1'b0, 1'b1, 3'h0, 2'b00}));
        rd(`TIRF_ADDR_EVENT_FLAGS_ONE, 8'h00, 8'hFF);
        fire(tirf_events_type'({4'h0, 1'b1, 1'b0, 3'h0, 2'b00}));
        rd(`TIRF_ADDR_EVENT_FLAGS_ONE, 8'h08, 8'hFF);
        check({8'h00, IRQ_ONE}, {8'h00, m & 8'h08});
        fire(tirf_events_type'({4'h0, 1'b0, 1'b0, 3'h0, 2'b11}));
        rd(`TIRF_ADDR_EVENT_FLAGS_TWO, 8'h70, 8'hFF);
        wr(`TIRF_ADDR_IRQ_ENABLE_TWO, 8'h31);
        @(posedge MCLK);
        #1;
        check({12'h000, IRQ_TWO}, 16'h0003);
        wr(`TIRF_ADDR_IRQ_ENABLE_TWO, 8'h40);
        // Period is timed from the timeout although the clear lands later
        for (int s = 0; s < 4; s++)
        begin
            @(posedge MCLK);
            PERIODIC_RATE_SELECT <= 2'(s);
            repeat (2)
            begin
                wait_periodic(n);
                wr(`TIRF_ADDR_EVENT_FLAGS_TWO, 8'h40);
            end
            wait_periodic(n);
            check(16'(n + 2), 16'(1 << (3 + s)));
        end
        @(posedge MCLK);
        PERIODIC_RATE_SELECT <= 2'h0;
        NORMAL_MODE <= 0;
        reset_dut();
        rd(`TIRF_ADDR_EVENT_FLAGS_TWO, 8'h00, 8'h40);
        // Last read before the first whole period ends, then the first one after it
        repeat (5) @(posedge MCLK);
        rd(`TIRF_ADDR_EVENT_FLAGS_TWO, 8'h00, 8'h40);
        rd(`TIRF_ADDR_EVENT_FLAGS_TWO, 8'h40, 8'h40);
        wr(`TIRF_ADDR_IRQ_ENABLE_TWO, 8'h83);
        wr(`TIRF_ADDR_IRQ_ENABLE_TWO, 8'h80);
        rd(`TIRF_ADDR_IRQ_ENABLE_TWO, 8'h80, 8'hFF);
        wr(`TIRF_ADDR_IRQ_ENABLE_TWO, 8'h82);
        @(posedge MCLK);
        #1;
        t0 = FREE_RUNNING_COUNTER;
        repeat (80) @(posedge MCLK);
        #1;
        check(FREE_RUNNING_COUNTER - t0, 16'd10);
        wr(`TIRF_ADDR_IRQ_ENABLE_TWO, 8'h80);
        n = 0;
        while (FREE_RUNNING_COUNTER !== `TIRF_COUNTER_MAX && n < 70000)
        begin
            @(posedge MCLK);
            #1;
            n++;
        end
        repeat (5) @(posedge MCLK);
        #1;
        check({15'h0000, IRQ_TWO[3]}, 16'h0001);
        wr(`TIRF_ADDR_IRQ_ENABLE_TWO, 8'h00);
        repeat (2) @(posedge MCLK);
        #1;
        check({15'h0000, IRQ_TWO[3]}, 16'h0000);
        rd(`TIRF_ADDR_EVENT_FLAGS_TWO, 8'h80, 8'h80);
        // A first write that comes after the window has closed is ignored
        NORMAL_MODE <= 1;
        reset_dut();
        repeat (70) @(posedge MCLK);
        wr(`TIRF_ADDR_IRQ_ENABLE_TWO, 8'h02);
        rd(`TIRF_ADDR_IRQ_ENABLE_TWO, 8'h00, 8'hFF);
        repeat (3) @(posedge MCLK);
        tally_and_finish();
    end
endmodule : tirf_top_tb
`default_nettype wire
